// ==== common/port_gate_pkg.sv ====
// Notes on behaviour
// - Each gating register holds five enables, bit 0 port A up to bit 4 port E.
// - A port whose applicable enable is one gets its clock, otherwise none.
// - An access aimed at a port whose clock is gated off ends in a bus fault.
// - Reset clears every enable bit so all ports start unclocked.
// - In normal running the enables come from the run-mode register.
// - Sleep takes the sleep-mode register, deep sleep the deep-sleep one.
// - The sleep registers apply only while the auto-gating bit is set.
// - The run register sits at 0x108 and the sleep register at 0x118.
// - The deep-sleep register sits at 0x128 with the same bits and reset.
package port_gate_pkg;

	// -----------------------------------------------------------------
	// Register map and fields
	// -----------------------------------------------------------------
	localparam logic [31:0] gate_base = 32'h400f_e000;
	localparam logic [11:0] run_gate_off = 12'h108;
	localparam logic [11:0] sleep_gate_off = 12'h118;
	localparam logic [11:0] deep_gate_off = 12'h128;
	localparam logic [11:0] clock_cfg_off = 12'h060;
	localparam int num_ports = 5;
	localparam int auto_gate_bit = 27;
	localparam logic [4:0] port_en_reset = 5'h00;
	localparam logic [31:0] fault_data = 32'h0000_0000;

	// Power mode of the system, Gray coded along run, sleep, deep sleep.
	typedef enum logic [1:0] {
		mode_run = 2'b00,
		mode_sleep = 2'b01,
		mode_deep = 2'b11
	} power_mode_t;

endpackage

// ==== verilog/port_clock_gate.sv ====
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
module port_clock_gate #(
	parameter int ports = 5
) (
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire port_gate_pkg::power_mode_t i_power_mode,
	input wire logic i_port_sel,
	input wire logic [2:0] i_port_index,
	output logic o_port_fault,
	output logic [4:0] o_port_clock_on
);
	import port_gate_pkg::*;

	// The enable registers, the read mux and the fault lookup are all
	// written for exactly five ports, so any other count is refused here.
	if (ports != num_ports) begin : g_bad_port_count
		$error("port count must equal five");
	end

	// -----------------------------------------------------------------
	// Register storage
	// -----------------------------------------------------------------
	logic [4:0] run_port_clock_enable_reg;
	logic [4:0] sleep_port_clock_enable_reg;
	logic [4:0] deepsleep_port_clock_enable_reg;
	logic auto_clock_gating_reg;
	logic [4:0] clock_on_reg;
	logic [4:0] clock_on_next;
	logic [31:0] prdata_next;

	// Address decode and write qualification are plain wires.
	wire access = i_psel && i_penable;
	wire wr_en = access && i_pwrite && i_pstrb[0];
	wire hit_run = (i_paddr == run_gate_off);
	wire hit_sleep = (i_paddr == sleep_gate_off);
	wire hit_deep = (i_paddr == deep_gate_off);
	wire hit_cfg = (i_paddr == clock_cfg_off);
	wire mapped = hit_run || hit_sleep || hit_deep || hit_cfg;
	wire cfg_wr = access && i_pwrite && i_pstrb[3] && hit_cfg;

	// Only byte lane 0 carries enables; upper bits are dropped.
	wire [4:0] wr_bits = i_pwdata[4:0];

	// Enable registers; every bit clears at reset.
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			run_port_clock_enable_reg <= port_en_reset;
			sleep_port_clock_enable_reg <= port_en_reset;
			deepsleep_port_clock_enable_reg <= port_en_reset;
			auto_clock_gating_reg <= 1'b0;
		end else begin
			if (wr_en && hit_run)
				run_port_clock_enable_reg <= wr_bits;
			if (wr_en && hit_sleep)
				sleep_port_clock_enable_reg <= wr_bits;
			if (wr_en && hit_deep)
				deepsleep_port_clock_enable_reg <= wr_bits;
			if (cfg_wr)
				auto_clock_gating_reg <= i_pwdata[auto_gate_bit];
		end
	end

	// -----------------------------------------------------------------
	// Enable selection by power mode
	// -----------------------------------------------------------------
	// Sleep registers are consulted only while auto-gating is set, so a
	// system that never sets it sees the run enables in every mode.
	always_comb begin
		clock_on_next = run_port_clock_enable_reg;
		if (auto_clock_gating_reg) begin
			case (i_power_mode)
				mode_run: clock_on_next = run_port_clock_enable_reg;
				mode_sleep: clock_on_next = sleep_port_clock_enable_reg;
				mode_deep: clock_on_next = deepsleep_port_clock_enable_reg;
				default: clock_on_next = run_port_clock_enable_reg;
			endcase
		end // otherwise run enables stay
	end

	// Registered so the gate controls never glitch between modes.
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			clock_on_reg <= port_en_reset;
		else
			clock_on_reg <= clock_on_next;
	end

	assign o_port_clock_on = clock_on_reg;

	// A port access is faulted while its clock is off. An index beyond
	// port E also faults, since no such port exists. The enables are
	// padded to eight bits so the lookup never reads past the vector,
	// which would give an unknown instead of a clean fault.
	wire [7:0] clock_on_wide = {3'h0, clock_on_reg};
	wire idx_ok = (i_port_index < 3'(num_ports));
	wire port_clock_off = !clock_on_wide[i_port_index];
	assign o_port_fault = i_port_sel &&
		(!idx_ok || port_clock_off);

	// -----------------------------------------------------------------
	// APB read path
	// -----------------------------------------------------------------
	always_comb begin
		prdata_next = fault_data;
		if (hit_run)
			prdata_next = {27'h0, run_port_clock_enable_reg};
		else if (hit_sleep)
			prdata_next = {27'h0, sleep_port_clock_enable_reg};
		else if (hit_deep)
			prdata_next = {27'h0, deepsleep_port_clock_enable_reg};
		else if (hit_cfg)
			prdata_next = 32'(auto_clock_gating_reg) << auto_gate_bit;
	end

	// Read data is captured in the setup cycle, ready in the access cycle.
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			o_prdata <= 32'h0000_0000;
		else if (i_psel && !i_penable && !i_pwrite)
			o_prdata <= prdata_next;
	end

	// The slave never stretches a transfer: every register is one flop
	// away from the bus, so ready is tied high and an unmapped offset is
	// flagged during the access phase only.
	assign o_pready = 1'b1;
	assign o_pslverr = access && !mapped;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	a_reset_clear: assert property (@(posedge i_sys_clk)
		$rose(i_arst_n) |-> run_port_clock_enable_reg == 5'h00)
		else $error("run enables not cleared by reset");
	a_run_write: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) wr_en && hit_run
		|=> run_port_clock_enable_reg == $past(i_pwdata[4:0]))
		else $error("run register write lost");
	a_run_mode_sel: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) i_power_mode == mode_run
		|=> o_port_clock_on == $past(run_port_clock_enable_reg))
		else $error("run mode not using run enables");
	a_sleep_sel: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n)
		auto_clock_gating_reg && i_power_mode == mode_sleep
		|=> o_port_clock_on == $past(sleep_port_clock_enable_reg))
		else $error("sleep enables not applied");
	a_no_auto_run: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) !auto_clock_gating_reg
		|=> o_port_clock_on == $past(run_port_clock_enable_reg))
		else $error("run enables not kept without auto gating");
	a_deep_sel: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n)
		auto_clock_gating_reg && i_power_mode == mode_deep
		|=> o_port_clock_on == $past(deepsleep_port_clock_enable_reg))
		else $error("deep sleep enables not applied");
	a_gated_fault: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) i_port_sel && i_port_index == 3'h2
		&& !o_port_clock_on[2] |-> o_port_fault)
		else $error("gated port access did not fault");
	a_clocked_ok: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) i_port_sel && i_port_index == 3'h0
		&& o_port_clock_on[0] |-> !o_port_fault)
		else $error("clocked port access faulted");
	a_reserved_zero: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) access && !i_pwrite && hit_deep
		|-> o_prdata[31:5] == 27'h0)
		else $error("reserved bits read nonzero");
	// Reserved bits are never stored, so every gating register must
	// return them as zero whatever software wrote there.
	a_run_reserved: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) access && !i_pwrite && hit_run
		|-> o_prdata[31:5] == 27'h0)
		else $error("run reserved bits read nonzero");
	a_sleep_reserved: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) access && !i_pwrite && hit_sleep
		|-> o_prdata[31:5] == 27'h0)
		else $error("sleep reserved bits read nonzero");

	// -----------------------------------------------------------------
	// Checks on the enable registers
	// -----------------------------------------------------------------
	// A register changes only on its own write; a stray decode that hit
	// two offsets at once would show up here first.
	a_sleep_write: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) wr_en && hit_sleep
		|=> sleep_port_clock_enable_reg == $past(i_pwdata[4:0]))
		else $error("sleep register write lost");
	a_deep_write: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) wr_en && hit_deep
		|=> deepsleep_port_clock_enable_reg == $past(i_pwdata[4:0]))
		else $error("deep sleep register write lost");
	a_run_hold: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) !(wr_en && hit_run)
		|=> $stable(run_port_clock_enable_reg))
		else $error("run register changed without a write");
	a_sleep_hold: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) !(wr_en && hit_sleep)
		|=> $stable(sleep_port_clock_enable_reg))
		else $error("sleep register changed without a write");
	a_deep_hold: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) !(wr_en && hit_deep)
		|=> $stable(deepsleep_port_clock_enable_reg))
		else $error("deep sleep register changed without a write");
	// At most one register offset may decode at a time.
	a_hit_onehot: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n)
		$onehot0({hit_run, hit_sleep, hit_deep, hit_cfg}))
		else $error("two register offsets decoded at once");
	// Only the auto-gating bit of the clock configuration is kept; the
	// rest of that register belongs to other logic.
	a_cfg_write: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) cfg_wr
		|=> auto_clock_gating_reg == $past(i_pwdata[auto_gate_bit]))
		else $error("auto gating bit write lost");
	// Reset is asynchronous, so the first edge after release must
	// already see every enable and the gate outputs at zero.
	a_reset_gates_off: assert property (@(posedge i_sys_clk)
		$rose(i_arst_n) |-> o_port_clock_on == 5'h00)
		else $error("port clocks running after reset");
	a_reset_sleep_clear: assert property (@(posedge i_sys_clk)
		$rose(i_arst_n) |-> sleep_port_clock_enable_reg == 5'h00
		&& deepsleep_port_clock_enable_reg == 5'h00
		&& !auto_clock_gating_reg)
		else $error("sleep enables not cleared by reset");

	// -----------------------------------------------------------------
	// Checks on clock selection
	// -----------------------------------------------------------------
	// The gate outputs trail the selection by one edge, hence the
	// non-overlapping implications against the sampled sources.
	a_deep_no_auto: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n)
		!auto_clock_gating_reg && i_power_mode == mode_deep
		|=> o_port_clock_on == $past(run_port_clock_enable_reg))
		else $error("deep sleep lost run enables");
	a_spare_mode_run: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) i_power_mode == power_mode_t'(2'b10)
		|=> o_port_clock_on == $past(run_port_clock_enable_reg))
		else $error("spare mode code not treated as run");
	a_clock_follows: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) 1'b1
		|=> o_port_clock_on == $past(clock_on_next))
		else $error("gate outputs not following the selection");

	// -----------------------------------------------------------------
	// Checks on port faults and the bus response
	// -----------------------------------------------------------------
	// An index past port E names no port at all and must always fault.
	a_range_fault: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) i_port_sel && i_port_index > 3'h4
		|-> o_port_fault)
		else $error("access to a missing port did not fault");
	a_gated_fault_e: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) i_port_sel && i_port_index == 3'h4
		&& !o_port_clock_on[4] |-> o_port_fault)
		else $error("gated port E access did not fault");
	a_clocked_any_ok: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n)
		i_port_sel && clock_on_wide[i_port_index] |-> !o_port_fault)
		else $error("access to a clocked port faulted");
	a_idle_no_fault: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) !i_port_sel |-> !o_port_fault)
		else $error("fault raised with no port access");
	// Known offsets complete cleanly; anything else is refused with
	// an error and reads back as zero.
	a_mapped_no_err: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) access && mapped |-> !o_pslverr)
		else $error("mapped register access flagged an error");
	a_unmapped_err: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) access && !mapped |-> o_pslverr)
		else $error("unmapped access not flagged");
	a_unmapped_zero: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) access && !i_pwrite && !mapped
		|-> o_prdata == fault_data)
		else $error("unmapped read returned data");
	// A master may rely on zero wait states at every access.
	a_ready_high: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) access |-> o_pready)
		else $error("slave stretched a transfer");
	// Read data must stand through the access phase and after it, or a
	// slow master would take a word that had already moved on.
	a_read_stands: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) !(i_psel && !i_penable && !i_pwrite)
		|=> $stable(o_prdata))
		else $error("read data moved outside a read setup");

	// Main scenarios the bench is expected to reach.

	c_run_write: cover property (@(posedge i_sys_clk) wr_en && hit_run);
	c_sleep_mode: cover property (@(posedge i_sys_clk)
		auto_clock_gating_reg && i_power_mode == mode_sleep);
	c_deep_mode: cover property (@(posedge i_sys_clk)
		auto_clock_gating_reg && i_power_mode == mode_deep);
	c_fault: cover property (@(posedge i_sys_clk) o_port_fault);
	c_cfg_write: cover property (@(posedge i_sys_clk) cfg_wr);

endmodule // port_clock_gate

// ==== dv/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
	import port_gate_pkg::*;
	// ---------------------------------------------------------------
	// Stimulus, design and checks
	// ---------------------------------------------------------------
	logic clk, arst_n, psel, penable, pwrite, pready, pslverr, rerr;
	logic port_sel, port_fault;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [2:0] port_index;
	logic [4:0] clock_on;
	power_mode_t mode;
	int err_total = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [11:0] offs [3] = '{run_gate_off, sleep_gate_off, deep_gate_off};
	port_clock_gate #(.ports(5)) i_dut (.i_sys_clk(clk), .i_arst_n(arst_n),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_power_mode(mode), .i_port_sel(port_sel),
		.i_port_index(port_index), .o_port_fault(port_fault),
		.o_port_clock_on(clock_on));
	// Free-running system clock at 25 MHz.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t: word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t: flag %b expected %b", $time, got, exp);
		end
	endtask
	// The request is held until pready is seen; the timeout cuts a hang.
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hf;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Enables go through one register stage, so wait two edges.
	task automatic clk_is(input power_mode_t m, input logic [4:0] exp);
		@(posedge clk);
		mode <= m;
		repeat (2) @(posedge clk);
		#1 chk_word({27'h0, clock_on}, {27'h0, exp});
	endtask
	task automatic fault_is(input logic [2:0] idx, input logic exp);
		@(posedge clk);
		port_sel <= 1'b1;
		port_index <= idx;
		#1 chk_bit(port_fault, exp);
		@(posedge clk);
		port_sel <= 1'b0;
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Cuts a hung handshake short; the whole run needs under 400 cycles.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			err_total++;
			$display("ERROR %0t: timeout", $time);
			print_verdict;
		end
	end
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		{arst_n, psel, penable, pwrite, port_sel} = 5'h00;
		{paddr, pwdata, pstrb, port_index} = '0;
		mode = mode_run;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		clk_is(mode_run, 5'h00);
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, offs[i], 32'h0);
			chk_word(rd, {27'h0, port_en_reset});
			chk_bit(rerr, 1'b0);
			apb(1'b1, offs[i], 32'hffff_ffff);
			apb(1'b0, offs[i], 32'h0);
			chk_word(rd, 32'h0000_001f);
		end
		apb(1'b1, run_gate_off, 32'h0000_0005);
		apb(1'b1, sleep_gate_off, 32'h0000_000a);
		apb(1'b1, deep_gate_off, 32'h0000_0011);
		clk_is(mode_run, 5'h05);
		for (int i = 0; i < 6; i++)
			fault_is(i[2:0], i > 3 || i % 2 == 1);
		clk_is(mode_sleep, 5'h05);
		clk_is(mode_deep, 5'h05);
		apb(1'b1, clock_cfg_off, 32'h1 << auto_gate_bit);
		clk_is(mode_sleep, 5'h0a);
		fault_is(3'h0, 1'b1);
		fault_is(3'h1, 1'b0);
		clk_is(mode_deep, 5'h11);
		clk_is(power_mode_t'(2'b10), 5'h05);
		apb(1'b0, run_gate_off, 32'h0);
		apb(1'b1, run_gate_off, rd | 32'h0000_0010);
		clk_is(mode_run, 5'h15);
		fault_is(3'h4, 1'b0);
		apb(1'b1, 12'h10c, 32'hffff_ffff);
		chk_bit(rerr, 1'b1);
		apb(1'b0, 12'h10c, 32'h0);
		chk_word(rd, fault_data);
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		#1 chk_word({27'h0, clock_on}, 32'h0);
		apb(1'b0, run_gate_off, 32'h0);
		chk_word(rd, 32'h0);
		print_verdict;
	end
endmodule // tb_top
